// >>> mcs_codec_model.sv
`timescale 1ns/1ps
module mcs_codec_model (
  // sampling clock and count clear
  input wire logic i_mclk,
  input wire logic i_clr,
  // master clocks seen by the codecs
  input wire logic i_clk1,
  input wire logic i_clk2,
  // rising edges counted since clear
  output int o_cnt1,
  output int o_cnt2
);
  logic p1_q = 1'b0;
  logic p2_q = 1'b0;
  always @(posedge i_mclk) begin
    o_cnt1 <= i_clr ? 0 : o_cnt1 + int'(i_clk1 && !p1_q);
    o_cnt2 <= i_clr ? 0 : o_cnt2 + int'(i_clk2 && !p2_q);
    p1_q <= i_clk1;
    p2_q <= i_clk2;
  end
endmodule

// >>> mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// register indices; the byte address is four times the index
`define MCS_CTRL_IDX 16'hffe1
`define MCS_GEN1_DIV_IDX 16'hffe2
`define MCS_GEN2_DIV_IDX 16'hfff6
`define MCS_IDX_HI 17
`define MCS_IDX_LO 2

// control register fields
`define MCS_OUT2_EN_BIT 7
`define MCS_OUT1_EN_BIT 6
`define MCS_RSVD_BIT 5
`define MCS_OUT1_SEL_HI 4
`define MCS_OUT1_SEL_LO 3
`define MCS_DIV_EN_BIT 2
`define MCS_OUT2_SEL_HI 1
`define MCS_OUT2_SEL_LO 0

// divider factor fields
`define MCS_M_FACTOR_HI 7
`define MCS_M_FACTOR_LO 4
`define MCS_I_FACTOR_HI 2
`define MCS_I_FACTOR_LO 0

// writable masks and reset values
`define MCS_CTRL_WMASK 8'hdf
`define MCS_GEN1_DIV_WMASK 8'hf7
`define MCS_GEN2_DIV_WMASK 8'hf0
`define MCS_CTRL_RESET 8'h00
`define MCS_DIV_RESET 8'h00

`endif

// >>> mcs_div_if.sv
`timescale 1ns/1ps
interface mcs_div_if #(parameter int FACTOR_W = 4);
  logic enable;
  logic src;
  logic [FACTOR_W-1:0] factor;
  logic out;
  modport div (input enable, input src, input factor, output out);
  modport ctl (output enable, output src, output factor, input out);
endinterface

// >>> mcs_divider.sv
`timescale 1ns/1ps
module mcs_divider #(
  parameter int FACTOR_W = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // divider channel
  mcs_div_if.div port
);

  logic prev_q;
  logic prev_d;
  logic [FACTOR_W-1:0] cnt_q;
  logic [FACTOR_W-1:0] cnt_d;
  logic out_q;
  logic out_d;

  always_comb begin
    prev_d = port.src;
    cnt_d = cnt_q;
    out_d = out_q;
    if (!port.enable) begin
      // stopped divider holds low
      cnt_d = '0;
      out_d = 1'b0;
    end else if (port.factor == '0) begin
      out_d = port.src;
    end else if (port.src && !prev_q) begin
      // divide by factor plus one, high for the first half
      cnt_d = (cnt_q >= port.factor) ? '0 : FACTOR_W'(cnt_q + 1'b1);
      out_d = (cnt_d <= (port.factor >> 1));
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign port.out = out_q;

endmodule

// >>> mcs_pkg.sv
package mcs_pkg;

  typedef logic [7:0] mcs_byte_t;

  typedef enum logic [1:0] {
    MCS_SRC_GEN1 = 2'b00,
    MCS_SRC_MCLKI = 2'b01,
    MCS_SRC_GEN2 = 2'b10,
    MCS_SRC_MCLKI_ALT = 2'b11
  } mcs_src_t;

  // low select bit set means the master clock input, whatever the high bit
  function automatic logic mcs_pick_src(input logic [1:0] sel, input logic gen1, input logic mclki,
                                        input logic gen2);
    logic res;
    res = 1'b0;
    unique case (mcs_src_t'(sel))
      MCS_SRC_GEN1: res = gen1;
      MCS_SRC_MCLKI, MCS_SRC_MCLKI_ALT: res = mclki;
      MCS_SRC_GEN2: res = gen2;
    endcase
    return res;
  endfunction

endpackage

// >>> mcs_top.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"

// Behaviour
// - bit 7 gates second output, else low
// - bit 6 gates first output, else low
// - bits 4:3 pick first output source
// - bits 1:0 pick second output source
// - dividers run only while bit 2 set
// - bit 5 reads zero; reset clears all
// - M factor 4 bits, divide by value+1
// - I factor 3 bits, divide by value+1
module mcs_top
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // source clocks from outside
  input wire logic i_first_generator_clock,
  input wire logic i_master_clock_in,
  input wire logic i_second_generator_clock,
  // codec master clocks
  output logic o_first_codec_clock_out,
  output logic o_second_codec_clock_out
);

  mcs_byte_t master_clock_output_control_q;
  mcs_byte_t master_clock_output_control_d;
  mcs_byte_t gen1_div_q;
  mcs_byte_t gen1_div_d;
  mcs_byte_t gen2_div_q;
  mcs_byte_t gen2_div_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [15:0] wr_idx_q;
  logic [15:0] wr_idx_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [2:0] sync1_q;
  logic [2:0] sync1_d;
  logic [2:0] sync2_q;
  logic [2:0] sync2_d;
  logic hreadyout_q;
  logic hreadyout_d;
  logic hresp_q;
  logic hresp_d;
  logic out1_en;
  logic out2_en;
  logic [1:0] out1_sel;
  logic [1:0] out2_sel;
  logic out1_q;
  logic out1_d;
  logic out2_q;
  logic out2_d;
  logic addr_ok;
  logic access;
  logic [15:0] req_idx;
  mcs_byte_t rd_byte;

  // one channel per divider: both generators and the master clock input
  mcs_div_if #(.FACTOR_W(4)) gen1_if ();
  mcs_div_if #(.FACTOR_W(4)) mclki_if ();
  mcs_div_if #(.FACTOR_W(4)) gen2_if ();

  // ---------------- register bus ----------------
  assign req_idx = i_haddr[`MCS_IDX_HI:`MCS_IDX_LO];
  assign addr_ok = (i_haddr[31:`MCS_IDX_HI+1] == '0) && (i_haddr[1:0] == 2'b00);
  assign access = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    master_clock_output_control_d = master_clock_output_control_q;
    gen1_div_d = gen1_div_q;
    gen2_div_d = gen2_div_q;
    wr_pend_d = access && i_hwrite && addr_ok;
    wr_idx_d = req_idx;
    hrdata_d = '0;
    rd_byte = '0;
    // a write lands at the end of its data phase, masked to its writable bits
    if (wr_pend_q) begin
      unique case (wr_idx_q)
        `MCS_CTRL_IDX: master_clock_output_control_d = i_hwdata[7:0] & `MCS_CTRL_WMASK;
        `MCS_GEN1_DIV_IDX: gen1_div_d = i_hwdata[7:0] & `MCS_GEN1_DIV_WMASK;
        `MCS_GEN2_DIV_IDX: gen2_div_d = i_hwdata[7:0] & `MCS_GEN2_DIV_WMASK;
        default: ;
      endcase
    end
    // reads see a write still in its data phase
    if (access && !i_hwrite && addr_ok) begin
      unique case (req_idx)
        `MCS_CTRL_IDX: rd_byte = master_clock_output_control_d;
        `MCS_GEN1_DIV_IDX: rd_byte = gen1_div_d;
        `MCS_GEN2_DIV_IDX: rd_byte = gen2_div_d;
        default: rd_byte = '0;
      endcase
      hrdata_d = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      master_clock_output_control_q <= `MCS_CTRL_RESET;
      gen1_div_q <= `MCS_DIV_RESET;
      gen2_div_q <= `MCS_DIV_RESET;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      master_clock_output_control_q <= master_clock_output_control_d;
      gen1_div_q <= gen1_div_d;
      gen2_div_q <= gen2_div_d;
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
    end
  end

  // zero wait states: ready rises on the first edge after reset and stays up
  always_comb begin
    hreadyout_d = 1'b1;
    hresp_d = 1'b0;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  assign o_hreadyout = hreadyout_q;
  assign o_hresp = hresp_q;
  assign o_hrdata = hrdata_q;

  // ---------------- source synchronisers ----------------
  // only the second stage feeds the dividers
  always_comb begin
    sync1_d = {i_second_generator_clock, i_master_clock_in, i_first_generator_clock};
    sync2_d = sync1_q;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ---------------- dividers ----------------
  // one shared enable stops all three dividers
  assign gen1_if.enable = master_clock_output_control_q[`MCS_DIV_EN_BIT];
  assign gen1_if.src = sync2_q[0];
  assign gen1_if.factor = gen1_div_q[`MCS_M_FACTOR_HI:`MCS_M_FACTOR_LO];
  assign mclki_if.enable = master_clock_output_control_q[`MCS_DIV_EN_BIT];
  assign mclki_if.src = sync2_q[1];
  assign mclki_if.factor = {1'b0, gen1_div_q[`MCS_I_FACTOR_HI:`MCS_I_FACTOR_LO]};
  assign gen2_if.enable = master_clock_output_control_q[`MCS_DIV_EN_BIT];
  assign gen2_if.src = sync2_q[2];
  assign gen2_if.factor = gen2_div_q[`MCS_M_FACTOR_HI:`MCS_M_FACTOR_LO];

  mcs_divider #(.FACTOR_W(4)) u_gen1_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .port(gen1_if.div)
  );

  mcs_divider #(.FACTOR_W(4)) u_mclki_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .port(mclki_if.div)
  );

  mcs_divider #(.FACTOR_W(4)) u_gen2_div (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .port(gen2_if.div)
  );

  // ---------------- output select and gating ----------------
  assign out1_en = master_clock_output_control_q[`MCS_OUT1_EN_BIT];
  assign out2_en = master_clock_output_control_q[`MCS_OUT2_EN_BIT];
  assign out1_sel = master_clock_output_control_q[`MCS_OUT1_SEL_HI:`MCS_OUT1_SEL_LO];
  assign out2_sel = master_clock_output_control_q[`MCS_OUT2_SEL_HI:`MCS_OUT2_SEL_LO];

  // a disabled pin is forced low, whatever its source does
  always_comb begin
    out1_d = out1_en && mcs_pick_src(out1_sel, gen1_if.out, mclki_if.out, gen2_if.out);
    out2_d = out2_en && mcs_pick_src(out2_sel, gen1_if.out, mclki_if.out, gen2_if.out);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      out1_q <= out1_d;
      out2_q <= out2_d;
    end
  end

  assign o_first_codec_clock_out = out1_q;
  assign o_second_codec_clock_out = out2_q;

endmodule

// >>> mcs_top_chk.sv
`timescale 1ns/1ps
module mcs_top_chk (
  input wire logic i_mclk, i_reset, i_hsel, i_hwrite, i_hready,
  input wire logic [1:0] i_htrans,
  input wire logic [31:0] i_haddr, i_hwdata,
  input wire logic o_hreadyout, o_hresp, o_first_codec_clock_out, o_second_codec_clock_out,
  input wire logic [31:0] o_hrdata
);
  logic [7:0] ctl_q;
  logic rd_q, wr_q, ca_q;
  wire logic tk = i_hsel && i_htrans[1] && i_hready;
  // shadow of the control register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ctl_q <= 8'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ca_q <= 1'b0;
    end else begin
      if (wr_q) ctl_q <= i_hwdata[7:0] & 8'hdf;
      wr_q <= tk && i_hwrite && i_haddr == 32'h0003_ff84;
      rd_q <= tk && !i_hwrite;
      ca_q <= i_haddr == 32'h0003_ff84;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence s_off1; !ctl_q[6] [*4]; endsequence
  sequence s_off2; !ctl_q[7] [*4]; endsequence
  sequence s_divoff; !ctl_q[2] [*4]; endsequence
  AST_OKAY: assert property (!o_hresp) else $error("bad response");
  AST_READY: assert property (!$past(i_reset) |-> o_hreadyout) else $error("wait state");
  AST_HI_ZERO: assert property (o_hrdata[31:8] == 24'h00_0000) else $error("upper read bits");
  AST_IDLE_DATA: assert property (!rd_q |-> o_hrdata == 32'h0000_0000) else $error("stale read data");
  AST_READBACK: assert property (rd_q && ca_q |-> o_hrdata[7:0] == ctl_q) else $error("control readback");
  AST_OUT1_OFF: assert property (s_off1 |-> !o_first_codec_clock_out) else $error("first out not low");
  AST_OUT2_OFF: assert property (s_off2 |-> !o_second_codec_clock_out) else $error("second out not low");
  AST_DIV_OFF: assert property (s_divoff |-> !o_first_codec_clock_out && !o_second_codec_clock_out)
    else $error("divider running");
endmodule
bind mcs_top mcs_top_chk u_chk (.i_mclk, .i_reset, .i_hsel, .i_hwrite, .i_hready, .i_htrans, .i_haddr, .i_hwdata,
  .o_hreadyout, .o_hresp, .o_first_codec_clock_out, .o_second_codec_clock_out, .o_hrdata);

// >>> mcs_top_tb.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_top_tb;
  localparam logic [31:0] CA = {14'h0, `MCS_CTRL_IDX, 2'b00};
  localparam logic [31:0] D1 = {14'h0, `MCS_GEN1_DIV_IDX, 2'b00};
  localparam logic [31:0] D2 = {14'h0, `MCS_GEN2_DIV_IDX, 2'b00};
  logic i_mclk = 0, i_reset = 1, hsel = 0, hwrite = 0, g1 = 0, mi = 0, g2 = 0, clr = 1, rdp = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, v;
  logic [31:0] q[$];
  wire logic rdy, resp, o1, o2;
  wire logic [31:0] rdata;
  int n_fail = 0, checks = 0, cyc = 0, c1, c2;
  // divider regs, control, expected periods of each output
  int tb[6][5] = '{'{'h32, 'h10, 'hc5, 32, 18}, '{'h32, 'h10, 'hd7, 20, 18}, '{'hff, 'h0f, 'hcc, 48, 128},
    '{'h32, 'h10, 'h05, 0, 0}, '{'h32, 'h10, 'hc1, 0, 0}, '{'h00, 'h00, 'hc6, 8, 10}};
  mcs_top dut (.i_mclk, .i_reset, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(rdata),
    .i_first_generator_clock(g1), .i_master_clock_in(mi), .i_second_generator_clock(g2),
    .o_first_codec_clock_out(o1), .o_second_codec_clock_out(o2));
  mcs_codec_model codec (.i_mclk, .i_clr(clr), .i_clk1(o1), .i_clk2(o2), .o_cnt1(c1), .o_cnt2(c2));
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    g1 <= (cyc % 8) < 4;
    mi <= (cyc % 6) < 3;
    g2 <= (cyc % 10) < 5;
    if (cyc == 10000) begin
      n_fail++;
      give_verdict();
    end
  end
  // read data monitor
  always @(posedge i_mclk) begin
    if (rdp) chk(rdata, q.pop_front());
    rdp = hsel && htrans[1] && rdy && !hwrite;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge i_mclk); end while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge i_mclk); end while (rdy !== 1'b1);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(0, a, 0);
  endtask
  task meas(input int n, input int p, input logic pin);
    int e;
    e = p ? 600 / p : 0;
    checks++;
    if (p == 0 ? (n != 0 || pin !== 1'b0) : (n < e - 1 || n > e + 1)) begin
      n_fail++;
      $display("[FAIL] %0t edges %0d expected near %0d", $time, n, e);
    end
  endtask
  task give_verdict;
    if (q.size() != 0) begin
      n_fail++;
      $display("[FAIL] %0t %0d reads never answered", $time, q.size());
    end
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(58756));
    repeat (4) @(posedge i_mclk);
    i_reset <= 0;
    repeat (2) @(posedge i_mclk);
    rd(CA, 0);
    rd(D1, 0);
    rd(D2, 0);
    rd(32'h0003_ff80, 0);
    repeat (8) begin
      v = $urandom;
      xfer(1, CA, v);
      rd(CA, v & 32'h0000_00df);
    end
    foreach (tb[i]) begin
      xfer(1, D1, tb[i][0]);
      xfer(1, D2, tb[i][1]);
      rd(D1, tb[i][0] & `MCS_GEN1_DIV_WMASK);
      rd(D2, tb[i][1] & `MCS_GEN2_DIV_WMASK);
      xfer(1, CA, tb[i][2]);
      repeat (40) @(posedge i_mclk);
      clr <= 1;
      @(posedge i_mclk);
      clr <= 0;
      repeat (600) @(posedge i_mclk);
      meas(c1, tb[i][3], o1);
      meas(c2, tb[i][4], o2);
    end
    give_verdict();
  end
endmodule
